/* bcdalu_pkg.sv */
/*
 * Shared constants and types of the BCD and real arithmetic block:
 * register offsets, command fields, opcodes and the flag layout.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */

package bcdalu_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_ACC   = 4'h0;
    localparam logic [3:0] ADDR_OPND  = 4'h4;
    localparam logic [3:0] ADDR_CMD   = 4'h8;
    localparam logic [3:0] ADDR_FLAGS = 4'hC;

    // ------------------------------------------------------------
    // Command register fields and reset values
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB    = 0;
    localparam int CMD_CONST_BIT = 4;
    localparam int CMD_PTR_BIT   = 5;
    localparam int CMD_PTROK_BIT = 6;
    localparam logic [31:0] ACC_RST  = 32'h0000_0000;
    localparam logic [31:0] OPND_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Arithmetic constants and bus response codes
    // ------------------------------------------------------------
    localparam logic [3:0] BCD_MAX   = 4'h9;
    localparam logic [4:0] BCD_ADJ   = 5'h06;
    localparam logic [7:0] EXP_ALL1  = 8'hFF;
    localparam logic [7:0] ALIGN_MAX = 8'h1A;
    localparam logic [4:0] NORM_POS  = 5'h1A;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLV  = 2'h2;

    // Instruction codes written into the command register.
    typedef enum logic [2:0] {
        OP_NONE    = 3'h0,
        OP_ADD32   = 3'h1,
        OP_ADDREAL = 3'h2,
        OP_SUB16   = 3'h3,
        OP_SUB32   = 3'h4
    } bcdalu_op_e;

    // Status flags, bit 0 is the zero flag.
    typedef struct packed {
        logic bad_operand_flag;
        logic underflow_flag;
        logic sign_error_flag;
        logic invalid_float_flag;
        logic invalid_pointer_flag;
        logic negative_flag;
        logic long_carry_flag;
        logic short_carry_flag;
        logic long_borrow_flag;
        logic short_borrow_flag;
        logic zero_flag;
    } bcdalu_flags_s;

    localparam bcdalu_flags_s FLAGS_RST = 11'h000;

endpackage : bcdalu_pkg

/* bcdalu_core.sv */
/*
 * Accumulator datapath for double BCD add, real add and single and
 * double BCD subtract, with its status flags, behind an AXI4-Lite
 * slave. Assumes one clock, a synchronous active-low reset and a
 * master that keeps to AXI4-Lite signalling.
 */
// Implementation choices: register access over AXI4-Lite and the address map.

`timescale 1ns/1ps

// Operation
// - Add 32-bit BCD operand into accumulator
// - Constant operand holds up to eight digits
// - Zero flag when accumulator ends zero
// - Short carry from 16-bit BCD add
// - Long carry from 32-bit BCD add
// - Negative flag when accumulator is negative
// - Bad operand on non-BCD digit
// - Flags hold latest affecting instruction result
// - Real add into accumulator
// - Real operands are IEEE single precision
// - Invalid pointer flag on bad pointer
// - Invalid float flag on bad accumulator
// - Sign error flag on overflow
// - Underflow flag on float underflow
// - Bad operand on non-real operand
// - Subtract word from low 16 bits
// - Short borrow from 16-bit subtract
// - Long borrow from 32-bit subtract
// - Subtract 32-bit operand from accumulator
module bcdalu_core #(
    parameter int ADDR_W = 4
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output bcdalu_pkg::bcdalu_flags_s flags
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [31:0]            acc;
    logic [31:0]            opnd;
    bcdalu_pkg::bcdalu_op_e op;
    logic                   via_ptr;
    logic                   ptr_ok;
    logic                   go;
    logic                   wr_fire;
    logic                   rd_fire;
    logic [3:0]             wr_addr;
    logic [3:0]             rd_addr;
    logic [31:0]            wr_merge;

    // Both write channels are taken together, once nothing is pending.
    assign s_axi_awready = ce && !s_axi_bvalid && s_axi_awvalid
                           && s_axi_wvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ce && !s_axi_rvalid;
    assign wr_fire = s_axi_awready;
    assign rd_fire = s_axi_arready && s_axi_arvalid;
    assign wr_addr = {s_axi_awaddr[3:2], 2'h0};
    assign rd_addr = {s_axi_araddr[3:2], 2'h0};

    // Byte lanes of a write merge into the word it targets.
    always_comb begin
        wr_merge = (wr_addr == bcdalu_pkg::ADDR_ACC) ? acc : opnd;
        for (int i = 0; i < 4; i++) begin
            if (s_axi_wstrb[i]) begin
                wr_merge[8*i+:8] = s_axi_wdata[8*i+:8];
            end
        end
    end

    // ------------------------------------------------------------
    // Write response channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= bcdalu_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_addr == bcdalu_pkg::ADDR_FLAGS)
                    ? bcdalu_pkg::RESP_OKAY : bcdalu_pkg::RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Command writes latch the instruction and fire it next cycle.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            op      <= bcdalu_pkg::OP_NONE;
            via_ptr <= 1'b0;
            ptr_ok  <= 1'b0;
            go      <= 1'b0;
            opnd    <= bcdalu_pkg::OPND_RST;
        end else if (ce) begin
            go <= 1'b0;
            if (wr_fire && wr_addr == bcdalu_pkg::ADDR_OPND) begin
                opnd <= wr_merge;
            end
            if (wr_fire && wr_addr == bcdalu_pkg::ADDR_CMD
                && s_axi_wstrb[0]) begin
                op <= bcdalu_pkg::bcdalu_op_e'(
                    s_axi_wdata[bcdalu_pkg::CMD_OP_LSB+:3]);
                // A constant operand never goes through a pointer.
                via_ptr <= s_axi_wdata[bcdalu_pkg::CMD_PTR_BIT]
                    && !s_axi_wdata[bcdalu_pkg::CMD_CONST_BIT];
                ptr_ok  <= s_axi_wdata[bcdalu_pkg::CMD_PTROK_BIT];
                go      <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= bcdalu_pkg::RESP_OKAY;
        end else if (ce) begin
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= bcdalu_pkg::RESP_OKAY;
                case (rd_addr)
                    bcdalu_pkg::ADDR_ACC:   s_axi_rdata <= acc;
                    bcdalu_pkg::ADDR_OPND:  s_axi_rdata <= opnd;
                    bcdalu_pkg::ADDR_CMD: begin
                        s_axi_rdata <= {25'h0000000, ptr_ok, via_ptr,
                                        1'b0, 1'b0, op};
                    end
                    default: s_axi_rdata <= {21'h000000, flags};
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // BCD adder and subtractor
    // ------------------------------------------------------------
    logic        is_sub;
    logic        is16;
    logic [8:0]  bcd_c;
    logic [31:0] bcd_sum;
    logic        bcd_bad;
    logic [3:0]  dig_a;
    logic [3:0]  dig_b;
    logic [4:0]  sum5;

    assign is_sub = (op == bcdalu_pkg::OP_SUB16)
                    || (op == bcdalu_pkg::OP_SUB32);
    assign is16   = (op == bcdalu_pkg::OP_SUB16);

    // Digit chain; subtract adds the nines complement plus one.
    always_comb begin
        dig_a   = 4'h0;
        dig_b   = 4'h0;
        sum5    = 5'h00;
        bcd_sum = 32'h0000_0000;
        bcd_bad = 1'b0;
        bcd_c   = {8'h00, is_sub};
        for (int i = 0; i < 8; i++) begin
            dig_a = acc[4*i+:4];
            dig_b = opnd[4*i+:4];
            if ((dig_a > bcdalu_pkg::BCD_MAX
                 || dig_b > bcdalu_pkg::BCD_MAX) && (i < 4 || !is16)) begin
                bcd_bad = 1'b1;
            end
            if (is_sub) begin
                dig_b = bcdalu_pkg::BCD_MAX - dig_b;
            end
            sum5 = {1'b0, dig_a} + {1'b0, dig_b} + {4'h0, bcd_c[i]};
            bcd_c[i+1] = (sum5 > {1'b0, bcdalu_pkg::BCD_MAX});
            if (bcd_c[i+1]) begin
                sum5 = sum5 + bcdalu_pkg::BCD_ADJ;
            end
            bcd_sum[4*i+:4] = sum5[3:0];
        end
    end

    // ------------------------------------------------------------
    // Single precision adder
    // ------------------------------------------------------------
    logic [31:0]       fx;
    logic [31:0]       fy;
    logic [26:0]       mx;
    logic [26:0]       my;
    logic [7:0]        sh;
    logic [27:0]       fsum;
    logic [4:0]        lead;
    logic signed [9:0] fexp;
    logic [27:0]       norm;
    logic [31:0]       fres;
    logic              f_ovf;
    logic              f_unf;
    logic              real_bad;

    // Non-numbers are refused; subnormals count as zero.
    assign real_bad = (acc[30:23] == bcdalu_pkg::EXP_ALL1)
                      || (opnd[30:23] == bcdalu_pkg::EXP_ALL1);

    // Align the smaller magnitude, add, then renormalise.
    always_comb begin
        fx = (opnd[30:0] > acc[30:0]) ? opnd : acc;
        fy = (opnd[30:0] > acc[30:0]) ? acc : opnd;
        mx = (fx[30:23] == 8'h00) ? 27'h0 : {1'b1, fx[22:0], 3'h0};
        my = (fy[30:23] == 8'h00) ? 27'h0 : {1'b1, fy[22:0], 3'h0};
        sh = fx[30:23] - fy[30:23];
        my = (sh > bcdalu_pkg::ALIGN_MAX) ? 27'h0 : (my >> sh);
        fsum = (fx[31] == fy[31]) ? ({1'b0, mx} + {1'b0, my})
                                  : ({1'b0, mx} - {1'b0, my});
        lead = 5'h00;
        for (int i = 0; i < 28; i++) begin
            if (fsum[i]) begin
                lead = 5'(i);
            end
        end
        fexp = $signed({2'h0, fx[30:23]}) + $signed({5'h00, lead})
               - $signed({5'h00, bcdalu_pkg::NORM_POS});
        norm = (lead > bcdalu_pkg::NORM_POS) ? (fsum >> 1)
               : (fsum << (bcdalu_pkg::NORM_POS - lead));
        f_ovf = 1'b0;
        f_unf = 1'b0;
        if (fsum == 28'h0) begin
            fres = 32'h0000_0000;
        end else if (fexp >= 10'sh0FF) begin
            fres  = {fx[31], bcdalu_pkg::EXP_ALL1, 23'h000000};
            f_ovf = 1'b1;
        end else if (fexp <= 10'sh000) begin
            fres  = {fx[31], 31'h0000_0000};
            f_unf = 1'b1;
        end else begin
            fres = {fx[31], fexp[7:0], norm[25:3]};
        end
    end

    // ------------------------------------------------------------
    // Execute: accumulator and flag update
    // ------------------------------------------------------------
    logic [31:0]               next_acc;
    bcdalu_pkg::bcdalu_flags_s next_flags;

    // Only flags the instruction uses change; a refused operand
    // leaves the accumulator alone.
    always_comb begin
        next_acc   = acc;
        next_flags = flags;
        next_flags.invalid_pointer_flag = via_ptr && !ptr_ok;
        if (!(via_ptr && !ptr_ok)) begin
            case (op)
                bcdalu_pkg::OP_ADD32: begin
                    next_flags.bad_operand_flag = bcd_bad;
                    if (!bcd_bad) begin
                        next_acc = bcd_sum;
                    end
                    next_flags.short_carry_flag = !bcd_bad
                                                  && bcd_c[4];
                    next_flags.long_carry_flag  = !bcd_bad
                                                  && bcd_c[8];
                end
                bcdalu_pkg::OP_SUB16, bcdalu_pkg::OP_SUB32: begin
                    next_flags.bad_operand_flag = bcd_bad;
                    if (!bcd_bad) begin
                        next_acc = is16 ? {acc[31:16], bcd_sum[15:0]}
                                        : bcd_sum;
                    end
                    next_flags.short_borrow_flag = !bcd_bad
                                                   && !bcd_c[4];
                    next_flags.long_borrow_flag  = !bcd_bad && !is16
                                                   && !bcd_c[8];
                end
                bcdalu_pkg::OP_ADDREAL: begin
                    next_flags.bad_operand_flag = real_bad;
                    if (!real_bad) begin
                        next_acc = fres;
                    end
                    next_flags.sign_error_flag = !real_bad && f_ovf;
                    next_flags.underflow_flag  = !real_bad && f_unf;
                    next_flags.invalid_float_flag =
                        (next_acc[30:23] == bcdalu_pkg::EXP_ALL1);
                end
                default: begin
                    next_acc = acc;
                end
            endcase
            if (op != bcdalu_pkg::OP_NONE) begin
                next_flags.zero_flag = (op == bcdalu_pkg::OP_ADDREAL)
                    ? (next_acc[30:0] == 31'h0)
                    : (next_acc == 32'h0000_0000);
                next_flags.negative_flag = next_acc[31];
            end
        end
    end

    // Accumulator takes bus writes, or the result when firing.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            acc <= bcdalu_pkg::ACC_RST;
        end else if (ce) begin
            if (go) begin
                acc <= next_acc;
            end else if (wr_fire && wr_addr == bcdalu_pkg::ADDR_ACC) begin
                acc <= wr_merge;
            end
        end
    end

    // Flags change only when an instruction fires.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flags <= bcdalu_pkg::FLAGS_RST;
        end else if (ce && go) begin
            flags <= next_flags;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    logic fire;
    assign fire = go && ce;

    zero_after_op_a: assert property (fire && op != bcdalu_pkg::OP_NONE
        && op != bcdalu_pkg::OP_ADDREAL && !(via_ptr && !ptr_ok)
        |=> flags.zero_flag == (acc == 32'h0))
        else $error("zero flag disagrees with accumulator");
    carry_long_a: assert property (fire && op == bcdalu_pkg::OP_ADD32
        && !via_ptr && acc == 32'h9999_9999 && opnd == 32'h1
        |=> flags.long_carry_flag && acc == 32'h0)
        else $error("long carry missed on wrap");
    carry_short_a: assert property (fire && op == bcdalu_pkg::OP_ADD32
        && !via_ptr && acc == 32'h0000_9999 && opnd == 32'h1
        |=> flags.short_carry_flag && !flags.long_carry_flag)
        else $error("short carry wrong");
    negative_flag_a: assert property (fire && op != bcdalu_pkg::OP_NONE
        && !(via_ptr && !ptr_ok)
        |=> flags.negative_flag == acc[31])
        else $error("negative flag disagrees with sign");
    bad_bcd_a: assert property (fire && op == bcdalu_pkg::OP_SUB32
        && !via_ptr && opnd[3:0] > 4'h9
        |=> flags.bad_operand_flag && $stable(acc))
        else $error("non-BCD operand not refused");
    pointer_bad_a: assert property (fire && via_ptr && !ptr_ok
        |=> flags.invalid_pointer_flag && $stable(acc))
        else $error("bad pointer not flagged");
    float_invalid_a: assert property (fire && op == bcdalu_pkg::OP_ADDREAL
        && !via_ptr |=> flags.invalid_float_flag
        == (acc[30:23] == 8'hFF))
        else $error("invalid float flag wrong");
    overflow_sign_a: assert property (fire
        && op == bcdalu_pkg::OP_ADDREAL
        |=> flags.sign_error_flag |-> flags.invalid_float_flag)
        else $error("overflow without infinite result");
    underflow_zero_a: assert property (fire
        && op == bcdalu_pkg::OP_ADDREAL && !via_ptr
        |=> flags.underflow_flag |-> acc[30:0] == 31'h0)
        else $error("underflow left nonzero value");
    sub16_upper_a: assert property (fire && op == bcdalu_pkg::OP_SUB16
        && !(via_ptr && !ptr_ok)
        |=> acc[31:16] == $past(acc[31:16])
        && !flags.long_borrow_flag)
        else $error("short subtract touched upper half");
    borrow_short_a: assert property (fire && op == bcdalu_pkg::OP_SUB16
        && !via_ptr && acc[15:0] == 16'h0 && opnd[15:0] == 16'h1
        |=> flags.short_borrow_flag && acc[15:0] == 16'h9999)
        else $error("short borrow missed");
    flags_kept_a: assert property (fire && op == bcdalu_pkg::OP_SUB32
        |=> $stable(flags.long_carry_flag)
        && $stable(flags.underflow_flag))
        else $error("unlisted flag changed");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid)
        else $error("write response dropped early");

    add_carry_c: cover property (fire && op == bcdalu_pkg::OP_ADD32
        ##1 flags.long_carry_flag);
    real_under_c: cover property (fire && op == bcdalu_pkg::OP_ADDREAL
        ##1 flags.underflow_flag);
    sub_borrow_c: cover property (fire && op == bcdalu_pkg::OP_SUB32
        ##1 flags.long_borrow_flag);

endmodule // bcdalu_core

/* bcd_real_add_subtract_alu_test.sv */
/*
 * Self-checking bench for the BCD and real arithmetic block: a table of
 * instructions run through the register bus, then reset, byte-strobe,
 * read-only and command read-back cases.
 * Assumes the block's package is compiled first; ce is driven here.
 */

`timescale 1ns/1ps

module bcd_real_add_subtract_alu_test;

    // ------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cmd;
        logic [31:0] acc;
        logic [31:0] opnd;
        logic [31:0] exp_acc;
        logic [10:0] exp_flags;
    } bcdalu_row_s;

    logic                      core_clk = 1'b0;
    logic                      rst_b    = 1'b0;
    logic                      ce       = 1'b1;
    logic [3:0]                awaddr   = 4'h0;
    logic                      awvalid  = 1'b0;
    logic                      awready;
    logic [31:0]               wdata    = 32'h0000_0000;
    logic [3:0]                wstrb    = 4'h0;
    logic                      wvalid   = 1'b0;
    logic                      wready;
    logic [1:0]                bresp;
    logic                      bvalid;
    logic                      bready   = 1'b0;
    logic [3:0]                araddr   = 4'h0;
    logic                      arvalid  = 1'b0;
    logic                      arready;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      rvalid;
    logic                      rready   = 1'b0;
    bcdalu_pkg::bcdalu_flags_s flags;
    logic [31:0]               got;
    logic [10:0]               exp_f;
    logic [10:0]               m;
    int                        n_fail   = 0;
    int                        tests_run = 0;

    // Columns: command, accumulator, operand, expected accumulator, flag values.
    bcdalu_row_s rows [17] = '{
        '{8'h01, 32'h12345678, 32'h87654321, 32'h99999999, 11'h020},
        '{8'h11, 32'h00009999, 32'h00000001, 32'h00010000, 11'h008},
        '{8'h01, 32'h99999999, 32'h00000001, 32'h00000000, 11'h019},
        '{8'h01, 32'h0000000A, 32'h00000001, 32'h0000000A, 11'h400},
        '{8'h03, 32'h12340050, 32'h00000051, 32'h12349999, 11'h002},
        '{8'h03, 32'h00000100, 32'h00000100, 32'h00000000, 11'h001},
        '{8'h04, 32'h00010000, 32'h00020000, 32'h99990000, 11'h024},
        '{8'h14, 32'h50000000, 32'h20000000, 32'h30000000, 11'h000},
        '{8'h02, 32'h3F800000, 32'h40000000, 32'h40400000, 11'h000},
        '{8'h02, 32'h40000000, 32'hC0400000, 32'hBF800000, 11'h020},
        '{8'h12, 32'h7F7FFFFF, 32'h7F7FFFFF, 32'h7F800000, 11'h180},
        '{8'h02, 32'h3F800000, 32'h7FC00000, 32'h3F800000, 11'h400},
        '{8'h02, 32'h00800000, 32'h80800001, 32'h80000000, 11'h221},
        '{8'h21, 32'h00000005, 32'h00000001, 32'h00000005, 11'h040},
        '{8'h61, 32'h00000005, 32'h00000001, 32'h00000006, 11'h000},
        '{8'h04, 32'h00000003, 32'h0000000B, 32'h00000003, 11'h400},
        '{8'h03, 32'h12340000, 32'h00000001, 32'h12349999, 11'h002}};

    bcdalu_core dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .flags(flags));

    // The clock toggles every 20 ns, a period of 40 ns.
    always #20 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compares one value and records any mismatch.
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // A bus wait that used up its bound ends the run.
    task automatic wait_bound(input int n);
        if (n >= 50) begin
            check(32'(n), 32'h0000_0000);
            finish_test();
        end
    endtask

    // One write: address and data offered together, then the response.
    task automatic bus_write(input logic [3:0] a, input logic [31:0] d,
                             input logic [3:0] s);
        int n;
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (awready !== 1'b1 && n < 50);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (bvalid !== 1'b1 && n < 50);
        check({30'h0, bresp}, 32'h0000_0000);
        bready <= 1'b0;
        wait_bound(n);
        // One idle edge keeps the next request off this release.
        @(posedge core_clk);
    endtask

    // One read: address offered, data taken at the rvalid edge.
    task automatic bus_read(input logic [3:0] a, output logic [31:0] d);
        int n;
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (arready !== 1'b1 && n < 50);
        arvalid <= 1'b0;
        do begin
            @(posedge core_clk);
            n++;
        end while (rvalid !== 1'b1 && n < 50);
        d = rdata;
        check({30'h0, rresp}, 32'h0000_0000);
        rready <= 1'b0;
        wait_bound(n);
        @(posedge core_clk);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        // Every register reads zero after reset.
        for (int i = 0; i < 4; i++) begin
            bus_read(4'(i * 4), got);
            check(got, 32'h0000_0000);
        end
        $display("reset value test done");
        exp_f = 11'h000;
        // Table rows: load both registers, run, read the outcome.
        foreach (rows[i]) begin
            bus_write(bcdalu_pkg::ADDR_ACC, rows[i].acc, 4'hF);
            bus_write(bcdalu_pkg::ADDR_OPND, rows[i].opnd, 4'hF);
            bus_write(bcdalu_pkg::ADDR_CMD, {24'h0, rows[i].cmd}, 4'hF);
            if (rows[i].cmd[5] && !rows[i].cmd[4] && !rows[i].cmd[6]) begin
                m = 11'h040;
            end else if (rows[i].cmd[2:0] == 3'h1) begin
                m = 11'h479;
            end else if (rows[i].cmd[2:0] == 3'h2) begin
                m = 11'h7E1;
            end else begin
                m = 11'h467;
            end
            exp_f = (exp_f & ~m) | (rows[i].exp_flags & m);
            bus_read(bcdalu_pkg::ADDR_ACC, got);
            check(got, rows[i].exp_acc);
            check({21'h0, flags}, {21'h0, exp_f});
            bus_read(bcdalu_pkg::ADDR_FLAGS, got);
            check(got, {21'h0, exp_f});
            $display("row %0d done", i);
        end
        // Writes to the flag word are ignored.
        bus_write(bcdalu_pkg::ADDR_FLAGS, 32'hFFFF_FFFF, 4'hF);
        bus_read(bcdalu_pkg::ADDR_FLAGS, got);
        check(got, {21'h0, exp_f});
        $display("flag write test done");
        // Byte strobes merge into the accumulator.
        bus_write(bcdalu_pkg::ADDR_ACC, 32'hAABB_CCDD, 4'hF);
        bus_write(bcdalu_pkg::ADDR_ACC, 32'h1122_3344, 4'h2);
        bus_read(bcdalu_pkg::ADDR_ACC, got);
        check(got, 32'hAABB_33DD);
        $display("strobe test done");
        // A constant operand clears the pointer bit on read-back.
        bus_write(bcdalu_pkg::ADDR_CMD, 32'h0000_0074, 4'hF);
        bus_read(bcdalu_pkg::ADDR_CMD, got);
        check(got, 32'h0000_0044);
        $display("command read-back test done");
        // A low clock enable holds the read ready low.
        ce <= 1'b0;
        @(posedge core_clk);
        check({31'h0, arready}, 32'h0000_0000);
        ce <= 1'b1;
        $display("clock enable test done");
        // A reset in mid-run clears the accumulator and every flag.
        rst_b <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        check({21'h0, flags}, 32'h0000_0000);
        bus_read(bcdalu_pkg::ADDR_ACC, got);
        check(got, 32'h0000_0000);
        $display("second reset test done");
        finish_test();
    end

endmodule // bcd_real_add_subtract_alu_test
